/* rtl/sbh_ctrl.sv */
`timescale 1ns/1ps
// What this block does
// - in dram cycles the three shared strobes act as column, write, row
// - direct strobe only for transfers flagged direct, source or dest
// - direct read data is not captured into the interface
// - read latency code 0..3 delays direct strobe after read data phase
// - direct write leaves the data bus floated
// - write latency code 0..3 delays direct strobe after write data phase
// - in hold, bus clock toggles if float bit 0, floats if 1
// - hold granted only after pending transactions have finished
// - hold disable set means hold requests are never granted
// - bus floats no earlier than two clocks after hold request low
// - hold ack goes low after the float, within two clocks
// - bus driven again 2..7 clocks after request high, ack then high
// - hold floats enables, data, address, strobes, cke, oe and direct
// - hold timings count periods of the selected interface clock
// - bus request output changes only on bus clock rising edge
module sbh_ctrl #(
  parameter int DW = 64,
  parameter int AW = 20
) (
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  input  wire logic          req_valid,
  input  wire logic [2:0]    req_cmd,
  input  wire logic [3:0]    req_cs,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic [DW-1:0] req_wdata,
  input  wire logic [7:0]    req_be,
  input  wire logic          direct_source_mode,
  input  wire logic          direct_dest_mode,
  input  wire logic          self_refresh_exit,
  input  wire logic [1:0]    direct_read_latency,
  input  wire logic [1:0]    direct_write_latency,
  input  wire logic          clock_out_float,
  input  wire logic          hold_disable,
  input  wire logic          hold_req_n,
  input  wire logic [DW-1:0] bus_data_in,
  output logic               req_taken,
  output logic [DW-1:0]      rd_data,
  output logic               rd_valid,
  output logic [3:0]         chip_enables_n,
  output logic [7:0]         byte_enables_n,
  output logic [AW-1:0]      bus_address,
  output logic [DW-1:0]      bus_data_out,
  output logic               bus_data_oe_n,
  output logic               bus_oe_n,
  output logic               dram_row_strobe_n,
  output logic               dram_col_strobe_n,
  output logic               dram_write_strobe_n,
  output logic               dram_clock_enable,
  output logic               extra_output_enable_n,
  output logic               direct_transfer_strobe,
  output logic               bus_clock_out,
  output logic               bus_clock_oe_n,
  output logic               bus_release_ack_n,
  output logic               bus_request_out
);

  typedef struct packed {
    sbh_pkg::sbh_state_t state;
    logic [2:0]          cnt;
    logic [2:0]          target;
    logic                direct;
    logic                write;
    logic                taken;
    logic [DW-1:0]       rdat;
    logic                rvld;
    logic [3:0]          cs_n;
    logic [7:0]          be_n;
    logic [AW-1:0]       addr;
    logic [DW-1:0]       dout;
    logic                dout_oe_n;
    logic                oe_n;
    logic [2:0]          stb;
    logic                cke;
    logic                pdt;
    logic                bclk;
    logic                bclk_oe_n;
    logic                ack_n;
    logic                busreq;
  } sbh_regs_t;

  sbh_regs_t s;
  sbh_regs_t next_s;
  localparam int PRE_ALL_IDX = sbh_pkg::PRE_ALL_BIT - 3;

  // request outputs rise, transfer and bus request outputs change, on the edge where the bus clock goes high; hold outputs change on any sys_clk edge
  logic rise;
  assign rise = ~s.bclk;

  always_comb begin
    next_s       = s;
    next_s.taken = 1'b0;
    next_s.rvld  = 1'b0;
    next_s.bclk  = ~s.bclk;
    if (rise) begin
      next_s.busreq = req_valid | (s.state != sbh_pkg::ST_IDLE);
    end
    unique case (s.state)
      sbh_pkg::ST_IDLE: begin
        // hold wins over a new request; nothing is in flight here
        if (!hold_req_n && !hold_disable) begin
          next_s.state = sbh_pkg::ST_HWAIT;
          next_s.cnt   = 3'h0;
        end else if (rise && req_valid) begin
          next_s.taken     = 1'b1;
          next_s.cs_n      = ~req_cs;
          next_s.be_n      = ~req_be;
          next_s.addr      = req_addr;
          next_s.dout      = req_wdata;
          next_s.cnt       = 3'h0;
          next_s.write     = (req_cmd == sbh_pkg::CMD_WRITE);
          next_s.direct    = 1'b0;
          next_s.target    = 3'h0;
          next_s.state     = sbh_pkg::ST_BUSY;
          unique case (req_cmd)
            sbh_pkg::CMD_READ: begin
              next_s.stb    = sbh_pkg::STB_READ;
              next_s.direct = direct_source_mode;
              next_s.target = sbh_pkg::CAS_LAT +
                              {1'b0, direct_read_latency};
            end
            sbh_pkg::CMD_WRITE: begin
              next_s.stb       = sbh_pkg::STB_WRITE;
              next_s.direct    = direct_dest_mode;
              next_s.target    = {1'b0, direct_write_latency};
              next_s.dout_oe_n = direct_dest_mode;
              next_s.pdt       = direct_dest_mode &&
                                 (direct_write_latency == 2'h0);
            end
            sbh_pkg::CMD_ACT:    next_s.stb = sbh_pkg::STB_ACT;
            sbh_pkg::CMD_PREALL: begin
              next_s.stb                = sbh_pkg::STB_PRE;
              next_s.addr[PRE_ALL_IDX]  = 1'b1;
            end
            sbh_pkg::CMD_DEACT: begin
              next_s.stb                = sbh_pkg::STB_PRE;
              next_s.addr[PRE_ALL_IDX]  = 1'b0;
            end
            sbh_pkg::CMD_REFRESH_CMD:   next_s.stb = sbh_pkg::STB_REFRESH_CMD;
            sbh_pkg::CMD_MODE:   next_s.stb = sbh_pkg::STB_MODE;
            sbh_pkg::CMD_SREF: begin
              next_s.stb   = sbh_pkg::STB_REFRESH_CMD;
              next_s.cke   = 1'b0;
              next_s.state = sbh_pkg::ST_SREF;
            end
          endcase
        end
      end
      sbh_pkg::ST_BUSY: begin
        if (rise) begin
          next_s.cs_n      = 4'hF;
          next_s.stb       = sbh_pkg::STB_NOP;
          next_s.dout_oe_n = 1'b1;
          next_s.pdt       = 1'b0;
          if (s.cnt == s.target && (s.pdt || !s.direct)) begin
            next_s.state = sbh_pkg::ST_IDLE;
          end else begin
            next_s.cnt = s.cnt + 3'h1;
            // direct strobe lasts one bus clock at data phase plus latency
            next_s.pdt = s.direct && (s.cnt + 3'h1 == s.target);
            // direct reads bypass the capture register
            if (!s.write && !s.direct &&
                (s.cnt + 3'h1 == sbh_pkg::CAS_LAT)) begin
              next_s.rdat = bus_data_in;
              next_s.rvld = 1'b1;
            end
          end
        end
      end
      sbh_pkg::ST_SREF: begin
        if (rise) begin
          next_s.cs_n = 4'hF;
          next_s.stb  = sbh_pkg::STB_NOP;
          if (self_refresh_exit) begin
            next_s.cke   = 1'b1;
            next_s.state = sbh_pkg::ST_IDLE;
          end
        end
      end
      sbh_pkg::ST_HWAIT: begin
        // counted in interface clocks, which is sys_clk itself
        if (s.cnt == sbh_pkg::HOLD_FLOAT_CYC) begin
          next_s.oe_n      = 1'b1;
          next_s.bclk_oe_n = clock_out_float;
          next_s.state     = sbh_pkg::ST_HFLOAT;
        end else begin
          next_s.cnt = s.cnt + 3'h1;
        end
      end
      sbh_pkg::ST_HFLOAT: begin
        next_s.ack_n     = 1'b0;
        next_s.bclk_oe_n = clock_out_float;
        next_s.state     = sbh_pkg::ST_HELD;
      end
      sbh_pkg::ST_HELD: begin
        next_s.bclk_oe_n = clock_out_float;
        // relies on the master holding request low past ack low
        if (hold_req_n) begin
          next_s.cnt   = 3'h0;
          next_s.state = sbh_pkg::ST_HRESUME;
        end
      end
      sbh_pkg::ST_HRESUME: begin
        next_s.bclk_oe_n = clock_out_float;
        if (s.cnt == sbh_pkg::HOLD_DRIVE_CYC) begin
          next_s.oe_n      = 1'b0;
          next_s.bclk_oe_n = 1'b0;
          next_s.state     = sbh_pkg::ST_HDRIVE;
        end else begin
          next_s.cnt = s.cnt + 3'h1;
        end
      end
      sbh_pkg::ST_HDRIVE: begin
        next_s.ack_n = 1'b1;
        next_s.state = sbh_pkg::ST_IDLE;
      end
      default: next_s.state = sbh_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s           <= '0;
      s.state     <= sbh_pkg::ST_IDLE;
      s.cs_n      <= 4'hF;
      s.be_n      <= 8'hFF;
      s.dout_oe_n <= 1'b1;
      s.stb       <= sbh_pkg::STB_NOP;
      s.cke       <= 1'b1;
      s.ack_n     <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign req_taken              = s.taken;
  assign rd_data                = s.rdat;
  assign rd_valid               = s.rvld;
  assign chip_enables_n         = s.cs_n;
  assign byte_enables_n         = s.be_n;
  assign bus_address            = s.addr;
  assign bus_data_out           = s.dout;
  // whole bus floats in hold, the data lanes also on reads and direct writes
  assign bus_data_oe_n          = s.dout_oe_n | s.oe_n;
  assign bus_oe_n               = s.oe_n;
  assign dram_row_strobe_n      = s.stb[2];
  assign dram_col_strobe_n      = s.stb[1];
  assign dram_write_strobe_n    = s.stb[0];
  assign dram_clock_enable      = s.cke;
  assign extra_output_enable_n  = 1'b1;
  assign direct_transfer_strobe = s.pdt;
  assign bus_clock_out          = s.bclk;
  assign bus_clock_oe_n         = s.bclk_oe_n;
  assign bus_release_ack_n      = s.ack_n;
  assign bus_request_out        = s.busreq;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  AST_READ_CAPTURE: assert property (
    $fell(dram_col_strobe_n) && dram_row_strobe_n &&
    dram_write_strobe_n && !s.direct |-> ##6 rd_valid)
    else $error("read data not captured three bus clocks after read");
  AST_DIRECT_NO_CAPTURE: assert property (
    s.state == sbh_pkg::ST_BUSY && s.direct && !s.write |-> !rd_valid)
    else $error("direct read data was captured");
  AST_DIRECT_WRITE_FLOAT: assert property (
    !dram_write_strobe_n && s.direct |-> bus_data_oe_n)
    else $error("direct write drove the data bus");
  AST_NO_STROBE_PLAIN: assert property (
    direct_transfer_strobe |-> s.direct)
    else $error("direct strobe on a plain transfer");
  AST_FLOAT_DELAY: assert property (
    $rose(bus_oe_n) |-> $past(hold_req_n, 2) == 1'b0 &&
                        $past(hold_disable, 2) == 1'b0)
    else $error("bus floated too early or while hold disabled");
  AST_ACK_AFTER_FLOAT: assert property (
    $rose(bus_oe_n) |=> !bus_release_ack_n && bus_oe_n)
    else $error("hold ack not low one clock after float");
  AST_RESUME: assert property (
    $rose(hold_req_n) && s.state == sbh_pkg::ST_HELD
    |-> ##[2:7] $fell(bus_oe_n) ##1 bus_release_ack_n)
    else $error("bus not driven again 2 to 7 clocks after hold end");
  AST_HOLD_FLOATS: assert property (
    !bus_release_ack_n && s.state != sbh_pkg::ST_HDRIVE
    |-> bus_oe_n && bus_data_oe_n)
    else $error("bus driven while hold acknowledged");
  AST_CLOCK_FLOAT: assert property (
    !bus_release_ack_n && s.state != sbh_pkg::ST_HDRIVE
    |-> bus_clock_oe_n == $past(clock_out_float))
    else $error("bus clock float does not follow its bit");
  AST_BUSREQ_EDGE: assert property (
    $changed(bus_request_out) |-> bus_clock_out)
    else $error("bus request changed off the rising bus clock");
  AST_SREF_CKE: assert property (
    !dram_clock_enable && !self_refresh_exit |=> !dram_clock_enable)
    else $error("clock enable left self refresh early");
  AST_CMD_SELECT: assert property (
    $changed({dram_row_strobe_n, dram_col_strobe_n, dram_write_strobe_n})
    && !dram_row_strobe_n |-> chip_enables_n != 4'hF)
    else $error("command issued without chip select");
  COV_READ: cover property ($rose(rd_valid));
  COV_DIRECT: cover property ($rose(direct_transfer_strobe));
  COV_HOLD: cover property ($fell(bus_release_ack_n) ##[1:20]
                            $rose(bus_release_ack_n));
  COV_SREF: cover property ($fell(dram_clock_enable));
endmodule

/* pkg/sbh_pkg.sv */
package sbh_pkg;
  // bus commands taken on the request port
  localparam logic [2:0] CMD_READ   = 3'h0;
  localparam logic [2:0] CMD_WRITE  = 3'h1;
  localparam logic [2:0] CMD_ACT    = 3'h2;
  localparam logic [2:0] CMD_PREALL = 3'h3;
  localparam logic [2:0] CMD_DEACT  = 3'h4;
  localparam logic [2:0] CMD_REFRESH_CMD   = 3'h5;
  localparam logic [2:0] CMD_MODE   = 3'h6;
  localparam logic [2:0] CMD_SREF   = 3'h7;
  // strobe codes {row, col, write}, active low
  localparam logic [2:0] STB_NOP    = 3'h7;
  localparam logic [2:0] STB_ACT    = 3'h3;
  localparam logic [2:0] STB_READ   = 3'h5;
  localparam logic [2:0] STB_WRITE  = 3'h4;
  localparam logic [2:0] STB_PRE    = 3'h2;
  localparam logic [2:0] STB_REFRESH_CMD   = 3'h1;
  localparam logic [2:0] STB_MODE   = 3'h0;
  // address bit that picks all banks on a precharge
  localparam int         PRE_ALL_BIT = 13;
  // read data arrives this many bus clocks after the command
  localparam logic [2:0] CAS_LAT     = 3'h3;
  // hold timings in interface clock periods
  localparam int         HOLD_FLOAT_MIN_E  = 2;
  localparam int         HOLD_DRIVE_MIN_E  = 2;
  localparam int         HOLD_DRIVE_MAX_E  = 7;
  localparam logic [2:0] HOLD_FLOAT_CYC = 3'(HOLD_FLOAT_MIN_E - 1);
  localparam logic [2:0] HOLD_DRIVE_CYC = 3'(HOLD_DRIVE_MIN_E - 1);
  typedef enum logic [7:0] {
    ST_IDLE    = 8'h01,
    ST_BUSY    = 8'h02,
    ST_SREF    = 8'h04,
    ST_HWAIT   = 8'h08,
    ST_HFLOAT  = 8'h10,
    ST_HELD    = 8'h20,
    ST_HRESUME = 8'h40,
    ST_HDRIVE  = 8'h80
  } sbh_state_t;
endpackage

/* tb/sbh_dram_model.sv */
`timescale 1ns/1ps
module sbh_dram_model (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  chip_enables_n,
  input  wire logic        dram_row_strobe_n,
  input  wire logic        dram_col_strobe_n,
  input  wire logic        dram_write_strobe_n,
  input  wire logic        bus_clock_out,
  input  wire logic [19:0] bus_address,
  input  wire logic [63:0] bus_data_out,
  input  wire logic        bus_data_oe_n,
  output logic      [63:0] bus_data_in
);
  logic [63:0] mem [16];
  logic [2:0]  cnt;
  logic [3:0]  ra;
  logic [2:0]  stb;
  logic        sel;
  assign stb = {dram_row_strobe_n, dram_col_strobe_n, dram_write_strobe_n};
  // command sampled once per bus clock, while that clock is high
  assign sel = bus_clock_out && chip_enables_n != 4'hF;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 3'h0;
      bus_data_in <= 64'h0;
    end else begin
      if (sel && stb == sbh_pkg::STB_READ) begin
        cnt <= 3'h1;
        ra <= bus_address[3:0];
      end else if (cnt != 3'h0) begin
        cnt <= cnt + 3'h1;
      end
      if (sel && stb == sbh_pkg::STB_WRITE && !bus_data_oe_n) begin
        mem[bus_address[3:0]] <= bus_data_out;
      end
      // one bus clock of data, three bus clocks after the command
      if (cnt == 3'h3 || cnt == 3'h4) begin
        bus_data_in <= mem[ra];
      end else begin
        // released bus must not look like a stale word
        bus_data_in <= ~bus_data_in;
      end
    end
  end
endmodule

/* tb/sbh_ctrl_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module sbh_ctrl_bench;
  logic        sys_clk, rstn, req_valid, direct_source_mode, direct_dest_mode;
  logic        self_refresh_exit, clock_out_float, hold_disable, hold_req_n;
  logic        req_taken, rd_valid, bus_data_oe_n, bus_oe_n, prev_req;
  logic        dram_row_strobe_n, dram_col_strobe_n, dram_write_strobe_n;
  logic        dram_clock_enable, extra_output_enable_n, bus_clock_out;
  logic        direct_transfer_strobe, bus_clock_oe_n, bus_release_ack_n;
  logic        bus_request_out;
  logic [1:0]  direct_read_latency, direct_write_latency;
  logic [2:0]  req_cmd;
  logic [3:0]  req_cs, chip_enables_n;
  logic [7:0]  req_be, byte_enables_n;
  logic [19:0] req_addr, bus_address;
  logic [63:0] req_wdata, bus_data_in, rd_data, bus_data_out;
  int          n_errors, n_checks, cyc;
  localparam logic [63:0] D = 64'hA5C3_1E0F_5AA5_3C96;

  sbh_ctrl DUT (
    .sys_clk(sys_clk), .rstn(rstn), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_cs(req_cs), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_be(req_be),
    .direct_source_mode(direct_source_mode),
    .direct_dest_mode(direct_dest_mode),
    .self_refresh_exit(self_refresh_exit),
    .direct_read_latency(direct_read_latency),
    .direct_write_latency(direct_write_latency),
    .clock_out_float(clock_out_float), .hold_disable(hold_disable),
    .hold_req_n(hold_req_n), .bus_data_in(bus_data_in),
    .req_taken(req_taken), .rd_data(rd_data), .rd_valid(rd_valid),
    .chip_enables_n(chip_enables_n), .byte_enables_n(byte_enables_n),
    .bus_address(bus_address), .bus_data_out(bus_data_out),
    .bus_data_oe_n(bus_data_oe_n), .bus_oe_n(bus_oe_n),
    .dram_row_strobe_n(dram_row_strobe_n),
    .dram_col_strobe_n(dram_col_strobe_n),
    .dram_write_strobe_n(dram_write_strobe_n),
    .dram_clock_enable(dram_clock_enable),
    .extra_output_enable_n(extra_output_enable_n),
    .direct_transfer_strobe(direct_transfer_strobe),
    .bus_clock_out(bus_clock_out), .bus_clock_oe_n(bus_clock_oe_n),
    .bus_release_ack_n(bus_release_ack_n),
    .bus_request_out(bus_request_out)
  );
  sbh_dram_model MEM (
    .sys_clk(sys_clk), .rstn(rstn), .chip_enables_n(chip_enables_n),
    .dram_row_strobe_n(dram_row_strobe_n),
    .dram_col_strobe_n(dram_col_strobe_n),
    .dram_write_strobe_n(dram_write_strobe_n),
    .bus_clock_out(bus_clock_out), .bus_address(bus_address),
    .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n),
    .bus_data_in(bus_data_in)
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      final_report();
    end
  end

  always @(posedge sys_clk) begin
    #1;
    if (rstn && bus_request_out !== prev_req)
      `CHK("busreq edge", 1'b1, bus_clock_out)
    prev_req = bus_request_out;
  end

  task automatic step();
    @(posedge sys_clk);
    req_valid <= 1'b0;
    #1;
  endtask

  // ends one ns after the edge that took the request
  task automatic issue(input logic [2:0] c, input logic [3:0] cs,
    input logic [19:0] a, input logic [63:0] d, input logic s, input logic t,
    input logic [1:0] l, input logic [2:0] stb);
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_cs <= cs;
    req_addr <= a;
    req_wdata <= d;
    direct_source_mode <= s;
    direct_dest_mode <= t;
    direct_read_latency <= l;
    direct_write_latency <= l;
    for (int i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      #1;
      if (req_taken === 1'b1) break;
    end
    `CHK("taken", 1'b1, req_taken)
    `CHK("strobes", stb, {dram_row_strobe_n, dram_col_strobe_n,
      dram_write_strobe_n})
    `CHK("cs", ~cs, chip_enables_n)
    `CHK("busreq", 1'b1, bus_request_out)
  endtask

  task automatic scan(input int s, input logic rv);
    for (int n = 0; n < 16; n++) begin
      if (n > 0) step();
      `CHK("pdt", n >= s && n < s + 2, direct_transfer_strobe)
      `CHK("rd_valid", rv && n == 6, rd_valid)
    end
  endtask

  task automatic t_rw();
    issue(sbh_pkg::CMD_WRITE, 4'h1, 20'h3, D, 1'b0, 1'b0, 2'h0,
      sbh_pkg::STB_WRITE);
    `CHK("wr oe", 1'b0, bus_data_oe_n)
    `CHK("wr data", D, bus_data_out)
    `CHK("wr be", ~req_be, byte_enables_n)
    `CHK("wr addr", 20'h3, bus_address)
    scan(-9, 1'b0);
    issue(sbh_pkg::CMD_READ, 4'h1, 20'h3, 64'h0, 1'b0, 1'b0, 2'h0,
      sbh_pkg::STB_READ);
    scan(-9, 1'b1);
    `CHK("rd data", D, rd_data)
    $display("test rw done");
  endtask

  task automatic t_direct();
    for (int l = 0; l < 4; l++) begin
      issue(sbh_pkg::CMD_WRITE, 4'h4, 20'h3, ~D, 1'b0, 1'b1, 2'(l),
        sbh_pkg::STB_WRITE);
      `CHK("pdt wr oe", 1'b1, bus_data_oe_n)
      scan(2 * l, 1'b0);
      issue(sbh_pkg::CMD_READ, 4'h8, 20'h3, 64'h0, 1'b1, 1'b0, 2'(l),
        sbh_pkg::STB_READ);
      scan(6 + 2 * l, 1'b0);
      `CHK("pdt rd data", D, rd_data)
    end
    $display("test direct done");
  endtask

  task automatic t_cmds();
    logic [2:0] cm [5] = '{sbh_pkg::CMD_ACT, sbh_pkg::CMD_PREALL,
      sbh_pkg::CMD_DEACT, sbh_pkg::CMD_REFRESH_CMD, sbh_pkg::CMD_MODE};
    logic [2:0] sb [5] = '{sbh_pkg::STB_ACT, sbh_pkg::STB_PRE,
      sbh_pkg::STB_PRE, sbh_pkg::STB_REFRESH_CMD, sbh_pkg::STB_MODE};
    for (int i = 0; i < 5; i++) begin
      issue(cm[i], 4'(1 << (i % 4)), i == 2 ? 20'h400 : 20'h0, D, 1'b0,
        1'b0, 2'h0, sb[i]);
      if (i == 1 || i == 2) `CHK("a13", i == 1, bus_address[10])
      step();
    end
    $display("test cmds done");
  endtask

  task automatic t_sref();
    issue(sbh_pkg::CMD_SREF, 4'h2, 20'h0, D, 1'b0, 1'b0, 2'h0,
      sbh_pkg::STB_REFRESH_CMD);
    `CHK("sref cke", 1'b0, dram_clock_enable)
    repeat (6) step();
    `CHK("sref cke held", 1'b0, dram_clock_enable)
    @(posedge sys_clk);
    self_refresh_exit <= 1'b1;
    for (int i = 0; i < 4 && dram_clock_enable !== 1'b1; i++) step();
    `CHK("sref exit", 1'b1, dram_clock_enable)
    @(posedge sys_clk);
    self_refresh_exit <= 1'b0;
    $display("test sref done");
  endtask

  task automatic t_hold(input logic flt);
    logic ck;
    @(posedge sys_clk);
    hold_req_n <= 1'b0;
    clock_out_float <= flt;
    for (int n = 1; n < 5; n++) begin
      @(posedge sys_clk);
      #1;
      `CHK("hold float", n >= 3, bus_oe_n)
      `CHK("hold ack", n < 4, bus_release_ack_n)
      `CHK("clk float", n >= 3 && flt, bus_clock_oe_n)
    end
    `CHK("data float", 1'b1, bus_data_oe_n)
    `CHK("extra oe", 1'b1, extra_output_enable_n)
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_cmd <= sbh_pkg::CMD_READ;
    #1;
    ck = bus_clock_out;
    // request stays low well past the ack, as the master must
    for (int n = 0; n < 8; n++) begin
      @(posedge sys_clk);
      #1;
      `CHK("held refuse", 1'b0, req_taken)
      `CHK("held clock", ~ck, bus_clock_out)
      ck = bus_clock_out;
    end
    @(posedge sys_clk);
    req_valid <= 1'b0;
    hold_req_n <= 1'b1;
    for (int n = 1; n < 5; n++) begin
      @(posedge sys_clk);
      #1;
      `CHK("resume", n < 3, bus_oe_n)
      `CHK("resume ack", n >= 4, bus_release_ack_n)
      `CHK("clk drive", n < 3 && flt, bus_clock_oe_n)
    end
    $display("test hold done");
  endtask

  task automatic t_hold_busy();
    int rv;
    int ak;
    rv = 0;
    ak = 0;
    issue(sbh_pkg::CMD_READ, 4'h1, 20'h3, 64'h0, 1'b0, 1'b0, 2'h0,
      sbh_pkg::STB_READ);
    @(posedge sys_clk);
    hold_req_n <= 1'b0;
    req_valid <= 1'b0;
    for (int n = 2; n < 17; n++) begin
      @(posedge sys_clk);
      #1;
      if (rd_valid === 1'b1) rv = n;
      if (bus_release_ack_n === 1'b0 && ak == 0) ak = n;
    end
    `CHK("busy rd", 6, rv)
    `CHK("busy ack", 1'b1, ak > 6 && ak < 13)
    @(posedge sys_clk);
    hold_req_n <= 1'b1;
    repeat (8) step();
    $display("test hold busy done");
  endtask

  task automatic t_hold_disable();
    @(posedge sys_clk);
    hold_disable <= 1'b1;
    hold_req_n <= 1'b0;
    repeat (20) begin
      @(posedge sys_clk);
      #1;
      `CHK("hold_disable", 2'h1, {bus_oe_n, bus_release_ack_n})
    end
    issue(sbh_pkg::CMD_ACT, 4'h1, 20'h0, D, 1'b0, 1'b0, 2'h0,
      sbh_pkg::STB_ACT);
    step();
    @(posedge sys_clk);
    hold_req_n <= 1'b1;
    hold_disable <= 1'b0;
    $display("test hold_disable done");
  endtask

  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req_cmd = 3'h0;
    req_cs = 4'h1;
    req_addr = 20'h0;
    req_wdata = 64'h0;
    req_be = 8'h5A;
    {direct_source_mode, direct_dest_mode, self_refresh_exit} = 3'h0;
    direct_read_latency = 2'h0;
    direct_write_latency = 2'h0;
    {clock_out_float, hold_disable} = 2'h0;
    hold_req_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    `CHK("rst ack", 1'b1, bus_release_ack_n)
    `CHK("rst cs", 4'hF, chip_enables_n)
    rstn <= 1'b1;
    t_rw();
    t_direct();
    t_cmds();
    t_sref();
    t_hold(1'b0);
    t_hold(1'b1);
    t_hold_busy();
    t_hold_disable();
    final_report();
  end
endmodule
